// file: hw/iss_pkg.sv
// constants shared by the i2c slave status block
// assumes a 32-bit axi4-lite register bus and byte offsets within one 256-byte window
package iss_pkg;
	// ==========================================================
	// register offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STAT = 8'h04;
	localparam logic [7:0] OFF_RXD = 8'h08;
	localparam logic [7:0] OFF_TXD = 8'h0C;
	localparam logic [7:0] OFF_ID0 = 8'h10;
	localparam logic [7:0] OFF_ALT = 8'h20;
	localparam int NUM_IDS = 4;

	// ==========================================================
	// control field positions
	localparam int CTL_W = 6;
	localparam int CTL_EN = 0;
	localparam int CTL_GC_EN = 1;
	localparam int CTL_STOP_IE = 2;
	localparam int CTL_RX_IE = 3;
	localparam int CTL_NACK_EN = 4;
	localparam int CTL_GC_CLR = 5;
	localparam logic [5:0] CTL_RST = 6'h00;

	// ==========================================================
	// status field positions
	localparam int ST_STOP = 10;
	localparam int ST_GCT_LO = 8;
	localparam int ST_GC = 7;
	localparam int ST_BUSY = 6;
	localparam int ST_NACK = 5;
	localparam int ST_OVF = 4;
	localparam int ST_RXQ = 3;

	// ==========================================================
	// general call codes and types
	localparam logic [7:0] GC_RESET_CODE = 8'h06;
	localparam logic [7:0] GC_PROG_CODE = 8'h04;
	localparam logic [1:0] GCT_NONE = 2'h0;
	localparam logic [1:0] GCT_RESET = 2'h1;
	localparam logic [1:0] GCT_PROG = 2'h2;
	localparam logic [1:0] GCT_ALT = 2'h3;

	// ==========================================================
	// reset values and sizes
	localparam logic [6:0] ID_RST = 7'h00;
	localparam logic [6:0] ALT_RST = 7'h00;
	localparam logic [7:0] TXD_RST = 8'hFF;
	localparam int RX_DEPTH_DEF = 4;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [3:0] BIT_END = 4'h9;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		BUS_IDLE,
		BUS_ADDR,
		BUS_GC2,
		BUS_RX,
		BUS_TX,
		BUS_WAIT
	} iss_bus_t;
endpackage

// file: hw/iss_line_sync.sv
// synchroniser and condition detector for the scl and sda pins
// assumes both pins arrive asynchronously and are far slower than mclk
`timescale 1ns/1ps
module iss_line_sync (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_s,
	output logic scl_rise,
	output logic scl_fall,
	output logic start_p,
	output logic stop_p
);
	// ==========================================================
	// two-stage synchronisers, third stage for edges
	logic [1:0] scl_ff_q;
	logic [1:0] sda_ff_q;
	logic scl_old_q;
	logic sda_old_q;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			scl_ff_q <= 2'h3;
			sda_ff_q <= 2'h3;
			scl_old_q <= 1'b1;
			sda_old_q <= 1'b1;
		end else begin
			scl_ff_q <= {scl_ff_q[0], scl_in};
			sda_ff_q <= {sda_ff_q[0], sda_in};
			scl_old_q <= scl_ff_q[1];
			sda_old_q <= sda_ff_q[1];
		end
	end

	// ==========================================================
	// conditions; sda moving while scl stays high is a start or stop
	assign sda_s = sda_ff_q[1];
	assign scl_rise = scl_ff_q[1] & ~scl_old_q;
	assign scl_fall = ~scl_ff_q[1] & scl_old_q;
	assign start_p = scl_ff_q[1] & scl_old_q & sda_old_q & ~sda_ff_q[1];
	assign stop_p = scl_ff_q[1] & scl_old_q & ~sda_old_q & sda_ff_q[1];
endmodule

// file: hw/iss_top.sv
// i2c slave with status flags, receive fifo and axi4-lite registers
// assumes an external open-drain bus; scl is only sensed, never stretched
// Contract
// - stop-after-start flag sits at status bit 10
// - stop after start and match sets flag
// - stop flag with enable raises interrupt
// - status register read clears stop flag
// - general call type field at bits 9:8
// - general call reset keeps type field
// - general call clear write clears type
// - any general call sets bit 7
// - general call reset restores register defaults
// - hardware general call second byte enters fifo
// - general call clear write clears bit 7
// - start condition with enable sets busy bit 6
// - busy clears on mismatch or stop
// - address nack sets bit 5 flag
// - push into full fifo sets bit 4
// - bit 3 set while fifo holds data
// - receive flag with enable raises interrupt
//
// Register access over AXI4-Lite and the register addresses were decided locally.
`timescale 1ns/1ps
module iss_top #(
	parameter int RX_DEPTH = iss_pkg::RX_DEPTH_DEF
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	output logic irq
);
	localparam int PW = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;
	localparam int CW = $clog2(RX_DEPTH + 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(RX_DEPTH);

	// ==========================================================
	// pin conditions
	logic sda_s;
	logic scl_rise;
	logic scl_fall;
	logic start_p;
	logic stop_p;

	iss_line_sync u_sync (
		.mclk(mclk),
		.rst_n(rst_n),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.sda_s(sda_s),
		.scl_rise(scl_rise),
		.scl_fall(scl_fall),
		.start_p(start_p),
		.stop_p(stop_p)
	);

	// ==========================================================
	// state declarations
	iss_pkg::iss_bus_t st_q;
	logic [3:0] cnt_q;
	logic [7:0] sh_q;
	logic [7:0] txsh_q;
	logic drv_q;
	logic armed_q;
	logic [iss_pkg::CTL_W-1:0] ctl_q;
	logic [6:0] id_q [iss_pkg::NUM_IDS];
	logic [6:0] alt_q;
	logic [7:0] txd_q;
	logic txv_q;
	logic [7:0] fifo_q [RX_DEPTH];
	logic [PW-1:0] wp_q;
	logic [PW-1:0] rp_q;
	logic [CW-1:0] cnt_rx_q;
	logic stop_f_q;
	logic [1:0] gct_q;
	logic gc_f_q;
	logic busy_q;
	logic nack_q;
	logic ovf_q;
	logic irq_q;

	// ==========================================================
	// address decisions
	logic [iss_pkg::NUM_IDS-1:0] id_hit_v;
	genvar gi;
	generate
		for (gi = 0; gi < iss_pkg::NUM_IDS; gi++) begin : g_id
			assign id_hit_v[gi] = (sh_q[7:1] == id_q[gi]);
		end
	endgenerate

	wire byte_done = scl_fall & (cnt_q == iss_pkg::BIT_ACK);
	wire in_addr = byte_done & (st_q == iss_pkg::BUS_ADDR);
	wire in_gc2 = byte_done & (st_q == iss_pkg::BUS_GC2);
	wire id_hit = |id_hit_v;
	wire rw_bit = sh_q[0];
	wire force_nack = ctl_q[iss_pkg::CTL_NACK_EN];
	wire is_gc = ctl_q[iss_pkg::CTL_GC_EN] & (sh_q[7:1] == 7'h00) & ~rw_bit;
	wire nack_rd = id_hit & rw_bit & (~txv_q | force_nack);
	wire nack_wr = id_hit & ~rw_bit & force_nack;
	wire addr_ok = is_gc | (id_hit & ~nack_rd & ~nack_wr);
	wire ack_now = (st_q == iss_pkg::BUS_ADDR) ? addr_ok :
		((st_q == iss_pkg::BUS_RX) | (st_q == iss_pkg::BUS_GC2));
	wire gc_rst = in_gc2 & (sh_q == iss_pkg::GC_RESET_CODE);
	wire gc_hw = in_gc2 & sh_q[0];
	wire fifo_full = (cnt_rx_q == FULL_CNT);
	wire fifo_nempty = (cnt_rx_q != '0);
	wire push = (byte_done & (st_q == iss_pkg::BUS_RX)) | gc_hw;
	wire tx_next = scl_rise & (cnt_q == iss_pkg::BIT_ACK) & (st_q == iss_pkg::BUS_TX);

	// ==========================================================
	// bus byte engine
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= iss_pkg::BUS_IDLE;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
		end else if (stop_p | (start_p & ~ctl_q[iss_pkg::CTL_EN])) begin
			st_q <= iss_pkg::BUS_IDLE;
			cnt_q <= 4'h0;
		end else if (start_p) begin
			st_q <= iss_pkg::BUS_ADDR;
			cnt_q <= 4'h0;
		end else if (scl_rise) begin
			if (cnt_q < iss_pkg::BIT_ACK) begin
				sh_q <= {sh_q[6:0], sda_s};
				cnt_q <= cnt_q + 4'h1;
			end else begin
				cnt_q <= iss_pkg::BIT_END;
				// master nack ends a read
				if (tx_next & sda_s) st_q <= iss_pkg::BUS_WAIT;
			end
		end else if (byte_done) begin
			case (st_q)
				iss_pkg::BUS_ADDR: begin
					if (is_gc) st_q <= iss_pkg::BUS_GC2;
					else if (addr_ok & rw_bit) st_q <= iss_pkg::BUS_TX;
					else if (addr_ok) st_q <= iss_pkg::BUS_RX;
					else st_q <= iss_pkg::BUS_WAIT;
				end
				iss_pkg::BUS_GC2: st_q <= iss_pkg::BUS_WAIT;
				default: st_q <= st_q;
			endcase
		end else if (scl_fall & (cnt_q == iss_pkg::BIT_END)) begin
			cnt_q <= 4'h0;
		end
	end

	// ==========================================================
	// sda drive: pull low for ack and for zero data bits
	wire drv_tx = (st_q == iss_pkg::BUS_TX) & ~txsh_q[7];
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) drv_q <= 1'b0;
		else if (start_p | stop_p) drv_q <= 1'b0;
		else if (byte_done) drv_q <= ack_now & (st_q != iss_pkg::BUS_TX);
		else if (scl_fall) drv_q <= drv_tx;
	end

	// transmit shifter; an empty buffer sends all ones
	// loads on each acked ninth bit, address ack included, so a byte is never loaded twice
	wire tx_load = tx_next & ~sda_s;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) txsh_q <= iss_pkg::TXD_RST;
		else if (tx_load) txsh_q <= txv_q ? txd_q : iss_pkg::TXD_RST;
		else if (scl_rise & (st_q == iss_pkg::BUS_TX) & (cnt_q < iss_pkg::BIT_ACK)) txsh_q <= {txsh_q[6:0], 1'b1};
	end

	assign sda_out = 1'b0;
	assign sda_oe_n = ~drv_q;

	// ==========================================================
	// axi4-lite write side; address and data held until both present
	logic aw_h_q;
	logic w_h_q;
	logic [7:0] awa_q;
	logic [31:0] wd_q;
	logic [3:0] ws_q;
	logic bvalid_q;
	logic [1:0] bresp_q;

	wire do_wr = aw_h_q & w_h_q & ~bvalid_q;
	wire wr_lane0 = do_wr & ws_q[0];
	wire wr_ctl = wr_lane0 & (awa_q == iss_pkg::OFF_CTRL);
	wire wr_txd = wr_lane0 & (awa_q == iss_pkg::OFF_TXD);
	wire wr_alt = wr_lane0 & (awa_q == iss_pkg::OFF_ALT);
	wire wr_id_sel = (awa_q[7:4] == iss_pkg::OFF_ID0[7:4]) & (awa_q[1:0] == 2'h0);
	wire [1:0] wr_id_ix = awa_q[3:2];
	wire wr_map = wr_ctl | wr_txd | wr_alt | (do_wr & wr_id_sel) |
		(awa_q == iss_pkg::OFF_STAT) | (awa_q == iss_pkg::OFF_RXD);
	wire s_wd_clr = wd_q[iss_pkg::CTL_GC_CLR];
	wire gc_clr = wr_ctl & s_wd_clr;

	assign s_axi_awready = ~aw_h_q;
	assign s_axi_wready = ~w_h_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			aw_h_q <= 1'b0;
			w_h_q <= 1'b0;
			awa_q <= 8'h00;
			wd_q <= 32'h0000_0000;
			ws_q <= 4'h0;
		end else begin
			if (s_axi_awvalid & ~aw_h_q) begin
				aw_h_q <= 1'b1;
				awa_q <= s_axi_awaddr;
			end else if (do_wr) aw_h_q <= 1'b0;
			if (s_axi_wvalid & ~w_h_q) begin
				w_h_q <= 1'b1;
				wd_q <= s_axi_wdata;
				ws_q <= s_axi_wstrb;
			end else if (do_wr) w_h_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bvalid_q <= 1'b0;
			bresp_q <= iss_pkg::RESP_OKAY;
		end else if (do_wr) begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_map ? iss_pkg::RESP_OKAY : iss_pkg::RESP_SLVERR;
		end else if (s_axi_bready) bvalid_q <= 1'b0;
	end

	// ==========================================================
	// software registers; general call reset returns them to defaults
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctl_q <= iss_pkg::CTL_RST;
			alt_q <= iss_pkg::ALT_RST;
			txd_q <= iss_pkg::TXD_RST;
			txv_q <= 1'b0;
		end else if (gc_rst) begin
			ctl_q <= iss_pkg::CTL_RST;
			alt_q <= iss_pkg::ALT_RST;
			txd_q <= iss_pkg::TXD_RST;
			txv_q <= 1'b0;
		end else begin
			// clear bit is a strobe, never stored
			if (wr_ctl) ctl_q <= {1'b0, wd_q[iss_pkg::CTL_W-2:0]};
			if (wr_alt) alt_q <= wd_q[6:0];
			if (wr_txd) txd_q <= wd_q[7:0];
			if (wr_txd) txv_q <= 1'b1;
			else if (tx_load) txv_q <= 1'b0;
		end
	end

	generate
		for (gi = 0; gi < iss_pkg::NUM_IDS; gi++) begin : g_idreg
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) id_q[gi] <= iss_pkg::ID_RST;
				else if (gc_rst) id_q[gi] <= iss_pkg::ID_RST;
				else if (wr_lane0 & wr_id_sel & (wr_id_ix == 2'(gi))) id_q[gi] <= wd_q[6:0];
			end
		end
	endgenerate

	// ==========================================================
	// axi4-lite read side; reads of status and rx data have side effects
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	wire rd_take = s_axi_arvalid & ~rvalid_q;
	wire [15:0] stat_w = {5'h00, stop_f_q, gct_q, gc_f_q, busy_q, nack_q, ovf_q,
		fifo_nempty, 3'h0};
	wire rd_stat = rd_take & (s_axi_araddr == iss_pkg::OFF_STAT);
	wire rd_rx = rd_take & (s_axi_araddr == iss_pkg::OFF_RXD);
	wire pop = rd_rx & fifo_nempty;
	wire ar_id = (s_axi_araddr[7:4] == iss_pkg::OFF_ID0[7:4]) & (s_axi_araddr[1:0] == 2'h0);
	wire [31:0] rd_mux =
		(s_axi_araddr == iss_pkg::OFF_CTRL) ? {26'h000_0000, ctl_q} :
		(s_axi_araddr == iss_pkg::OFF_STAT) ? {16'h0000, stat_w} :
		(s_axi_araddr == iss_pkg::OFF_RXD) ? {24'h00_0000, fifo_q[rp_q]} :
		(s_axi_araddr == iss_pkg::OFF_TXD) ? {24'h00_0000, txd_q} :
		(s_axi_araddr == iss_pkg::OFF_ALT) ? {25'h000_0000, alt_q} :
		ar_id ? {25'h000_0000, id_q[s_axi_araddr[3:2]]} : 32'h0000_0000;
	wire rd_map = (s_axi_araddr == iss_pkg::OFF_CTRL) | (s_axi_araddr == iss_pkg::OFF_STAT) |
		(s_axi_araddr == iss_pkg::OFF_RXD) | (s_axi_araddr == iss_pkg::OFF_TXD) |
		(s_axi_araddr == iss_pkg::OFF_ALT) | ar_id;

	assign s_axi_arready = ~rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= iss_pkg::RESP_OKAY;
		end else if (rd_take) begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_mux;
			rresp_q <= rd_map ? iss_pkg::RESP_OKAY : iss_pkg::RESP_SLVERR;
		end else if (s_axi_rready) rvalid_q <= 1'b0;
	end

	// ==========================================================
	// receive fifo; a byte arriving when full is dropped
	always_ff @(posedge mclk) begin
		if (push & ~fifo_full) fifo_q[wp_q] <= sh_q;
	end

	wire do_push = push & ~fifo_full;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_rx_q <= '0;
		end else if (gc_rst) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_rx_q <= '0;
		end else begin
			if (do_push) wp_q <= (wp_q == PW'(RX_DEPTH - 1)) ? '0 : wp_q + PW'(1);
			if (pop) rp_q <= (rp_q == PW'(RX_DEPTH - 1)) ? '0 : rp_q + PW'(1);
			cnt_rx_q <= cnt_rx_q + CW'(do_push) - CW'(pop);
		end
	end

	// ==========================================================
	// status flags; a hardware set wins over a clear in the same cycle
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			armed_q <= 1'b0;
			stop_f_q <= 1'b0;
			busy_q <= 1'b0;
			nack_q <= 1'b0;
			ovf_q <= 1'b0;
		end else begin
			if (stop_p) armed_q <= 1'b0;
			else if (in_addr & (id_hit | is_gc)) armed_q <= 1'b1;
			if (stop_p & armed_q) stop_f_q <= 1'b1;
			else if (rd_stat | gc_rst) stop_f_q <= 1'b0;
			if (start_p & ctl_q[iss_pkg::CTL_EN]) busy_q <= 1'b1;
			else if (stop_p | (in_addr & ~(id_hit | is_gc)) | gc_rst) busy_q <= 1'b0;
			if (in_addr & (nack_rd | nack_wr)) nack_q <= 1'b1;
			else if (start_p | gc_rst) nack_q <= 1'b0;
			if (push & fifo_full) ovf_q <= 1'b1;
			else if (push | pop | gc_rst) ovf_q <= 1'b0;
		end
	end

	// general call flag and type survive the general call reset
	wire [1:0] gct_new = (sh_q == iss_pkg::GC_RESET_CODE) ? iss_pkg::GCT_RESET :
		(sh_q == iss_pkg::GC_PROG_CODE) ? iss_pkg::GCT_PROG :
		(sh_q[0] & (sh_q[7:1] == alt_q)) ? iss_pkg::GCT_ALT : gct_q;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			gc_f_q <= 1'b0;
			gct_q <= iss_pkg::GCT_NONE;
		end else begin
			if (in_gc2) gc_f_q <= 1'b1;
			else if (gc_clr) gc_f_q <= 1'b0;
			// type codes; kept on reset; clear write
			if (in_gc2) gct_q <= gct_new;
			else if (gc_clr) gct_q <= iss_pkg::GCT_NONE;
		end
	end

	// ==========================================================
	// interrupt request, registered
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) irq_q <= 1'b0;
		else irq_q <= (stop_f_q & ctl_q[iss_pkg::CTL_STOP_IE]) |
			(fifo_nempty & ctl_q[iss_pkg::CTL_RX_IE]);
	end
	assign irq = irq_q;
	wire unused_ok = stat_w[iss_pkg::ST_STOP] | ^ws_q[3:1];
endmodule

// file: testbench/iss_chk.sv
// checker for the register bus and the sda_out pin of the i2c slave status block
// assumes it is bound to iss_top and sees only its ports
`timescale 1ns/1ps
module iss_chk (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic sda_out
);
	// ==========================================================
	// address of the read under way
	logic [7:0] ar_q;
	logic [7:0] ar_d;
	wire ar_take = s_axi_arvalid & s_axi_arready;
	wire unmapped = (ar_q > iss_pkg::OFF_ALT) | (ar_q[1:0] != 2'h0);
	assign ar_d = ar_take ? s_axi_araddr : ar_q;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) ar_q <= 8'h00;
		else ar_q <= ar_d;
	end

	// ==========================================================
	// properties
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
	read_answer_a: assert property (ar_take |=> s_axi_rvalid) else $error("read data late");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
		&& $stable(s_axi_bresp)) else $error("write response dropped");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata)) else $error("read data dropped");
	ar_ready_a: assert property (s_axi_arready == !s_axi_rvalid) else $error("arready wrong");
	unmapped_read_a: assert property (s_axi_rvalid && unmapped |-> s_axi_rresp == 2'h2
		&& s_axi_rdata == 32'h0000_0000) else $error("unmapped read answered");
	status_width_a: assert property (s_axi_rvalid && ar_q == iss_pkg::OFF_STAT
		|-> s_axi_rdata[31:11] == 21'h0) else $error("status upper bits set");
	sda_low_a: assert property (sda_out == 1'b0) else $error("sda drive level high");
endmodule

bind iss_top iss_chk u_chk (.mclk(mclk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .sda_out(sda_out));

// file: testbench/iss_i2c_master.sv
// behavioural i2c bus master driving scl and sda, 64 ns bit period
// assumes a pulled-up sda wire; released lines read 1, scl stands high between frames
`timescale 1ns/1ps
module iss_i2c_master (
	input wire logic sda_line,
	output logic scl,
	output logic sda
);
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
	// long low phase so the slave's ack release lands before scl rises
	task automatic put_bit(input logic b, output logic r);
		#24 sda = b;
		#24 scl = 1'b1;
		#14 r = sda_line;
		#2 scl = 1'b0;
	endtask
	task automatic start();
		#3 sda = 1'b0;
		#32 scl = 1'b0;
	endtask
	task automatic stop();
		#24 sda = 1'b0;
		#24 scl = 1'b1;
		#24 sda = 1'b1;
		#40;
	endtask
	task automatic put_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) put_bit(d[i], r);
		put_bit(1'b1, r);
		ack = !r;
	endtask
	// reads a byte with sda released, then acks (last=0) or nacks (last=1)
	task automatic get_byte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			put_bit(1'b1, r);
			d[i] = r;
		end
		put_bit(last, r);
	endtask
endmodule

// file: testbench/test_i2c_slave_status_logic.sv
// self-checking bench for the i2c slave status block
// assumes the bound checker and a behavioural bus master on the pins
`timescale 1ns/1ps
module test_i2c_slave_status_logic;
	logic mclk, rst_n, awvalid, wvalid, bready, arvalid, rready, bvalid, rvalid;
	logic awready, wready, arready, scl, m_sda, sda_out, sda_oe_n, irq, ack;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	int miscompares, comparisons;
	wire sda_line = m_sda & (sda_oe_n | sda_out);

	iss_top #(.RX_DEPTH(2)) dut (.mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n), .irq(irq));
	iss_i2c_master m (.sda_line(sda_line), .scl(scl), .sda(m_sda));

	// ==========================================================
	// common tasks
	task automatic summarize();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic timeout();
		miscompares++;
		summarize();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		bit ad, dd;
		@(posedge mclk);
		awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		for (int i = 0; i <= 100; i++) begin
			if (i == 100) timeout();
			@(posedge mclk);
			if (!ad && awready) begin ad = 1; awvalid <= 1'b0; end
			if (!dd && wready) begin dd = 1; wvalid <= 1'b0; end
			if (bvalid) begin r = bresp; bready <= 1'b0; break; end
		end
	endtask
	task automatic rd(input logic [7:0] a);
		bit ad;
		@(posedge mclk);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		for (int i = 0; i <= 100; i++) begin
			if (i == 100) timeout();
			@(posedge mclk);
			if (!ad && arready) begin ad = 1; arvalid <= 1'b0; end
			if (rvalid) begin d = rdata; r = rresp; rready <= 1'b0; break; end
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] e);
		rd(a);
		chk(d & mask, e);
	endtask
	task automatic send(input logic [7:0] b, input logic e);
		m.put_byte(b, ack);
		chk({31'h0, ack}, {31'h0, e});
	endtask

	// ==========================================================
	// scenarios
	task automatic s_regs();
		rd_chk(iss_pkg::OFF_STAT, 32'hFFFF_FFFF, 32'h0000_0000);
		rd_chk(iss_pkg::OFF_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
		rd(8'h40);
		chk({30'h0, r}, {30'h0, iss_pkg::RESP_SLVERR});
		wr(8'h44, 32'h0000_0001);
		chk({30'h0, r}, {30'h0, iss_pkg::RESP_SLVERR});
		wr(iss_pkg::OFF_STAT, 32'h0000_FFFF);
		rd_chk(iss_pkg::OFF_STAT, 32'hFFFF_FFFF, 32'h0000_0000);
	endtask
	task automatic s_write();
		wr(iss_pkg::OFF_ID0, 32'h0000_002A);
		wr(iss_pkg::OFF_CTRL, 32'h0000_0005);
		m.start();
		rd_chk(iss_pkg::OFF_STAT, 32'h0000_0040, 32'h0000_0040);
		send(8'h54, 1'b1);
		send(8'hA5, 1'b1);
		send(8'h3C, 1'b1);
		rd_chk(iss_pkg::OFF_STAT, 32'h0000_0448, 32'h0000_0048);
		m.stop();
		chk({31'h0, irq}, 32'h0000_0001);
		rd_chk(iss_pkg::OFF_STAT, 32'hFFFF_FFFF, 32'h0000_0408);
		rd_chk(iss_pkg::OFF_STAT, 32'hFFFF_FFFF, 32'h0000_0008);
		repeat (2) @(posedge mclk);
		chk({31'h0, irq}, 32'h0000_0000);
		wr(iss_pkg::OFF_CTRL, 32'h0000_0009);
		repeat (2) @(posedge mclk);
		chk({31'h0, irq}, 32'h0000_0001);
		rd_chk(iss_pkg::OFF_RXD, 32'h0000_00FF, 32'h0000_00A5);
		rd_chk(iss_pkg::OFF_RXD, 32'h0000_00FF, 32'h0000_003C);
		repeat (2) @(posedge mclk);
		chk({31'h0, irq}, 32'h0000_0000);
		rd_chk(iss_pkg::OFF_STAT, 32'h0000_0008, 32'h0000_0000);
	endtask
	task automatic s_overflow();
		// third byte meets a full two-deep fifo and is lost
		m.start();
		send(8'h54, 1'b1);
		send(8'h11, 1'b1);
		send(8'h22, 1'b1);
		m.put_byte(8'h33, ack);
		m.stop();
		rd_chk(iss_pkg::OFF_STAT, 32'hFFFF_FFFF, 32'h0000_0418);
		rd_chk(iss_pkg::OFF_RXD, 32'h0000_00FF, 32'h0000_0011);
		rd_chk(iss_pkg::OFF_STAT, 32'hFFFF_FFFF, 32'h0000_0008);
		rd_chk(iss_pkg::OFF_RXD, 32'h0000_00FF, 32'h0000_0022);
		rd_chk(iss_pkg::OFF_STAT, 32'hFFFF_FFFF, 32'h0000_0000);
	endtask
	task automatic s_read();
		logic [7:0] b;
		wr(iss_pkg::OFF_TXD, 32'h0000_00C3);
		m.start();
		send(8'h55, 1'b1);
		m.get_byte(1'b1, b);
		chk({24'h0, b}, 32'h0000_00C3);
		m.stop();
		rd_chk(iss_pkg::OFF_STAT, 32'h0000_0060, 32'h0000_0000);
		wr(iss_pkg::OFF_CTRL, 32'h0000_0011);
		m.start();
		send(8'h54, 1'b0);
		m.stop();
		rd_chk(iss_pkg::OFF_STAT, 32'h0000_0020, 32'h0000_0020);
		wr(iss_pkg::OFF_CTRL, 32'h0000_0009);
	endtask
	task automatic s_nack();
		m.start();
		send(8'h55, 1'b0);
		m.stop();
		rd_chk(iss_pkg::OFF_STAT, 32'h0000_0020, 32'h0000_0020);
		m.start();
		send(8'h22, 1'b0);
		rd_chk(iss_pkg::OFF_STAT, 32'h0000_0060, 32'h0000_0000);
		m.stop();
		rd_chk(iss_pkg::OFF_STAT, 32'h0000_0400, 32'h0000_0000);
	endtask
	task automatic s_gc();
		wr(iss_pkg::OFF_CTRL, 32'h0000_0003);
		wr(iss_pkg::OFF_ALT, 32'h0000_0035);
		m.start();
		send(8'h00, 1'b1);
		send(iss_pkg::GC_PROG_CODE, 1'b1);
		m.stop();
		rd_chk(iss_pkg::OFF_STAT, 32'hFFFF_FFFF, 32'h0000_0680);
		m.start();
		send(8'h00, 1'b1);
		send(8'h6B, 1'b1);
		m.stop();
		rd_chk(iss_pkg::OFF_STAT, 32'hFFFF_FFFF, 32'h0000_0788);
		rd_chk(iss_pkg::OFF_RXD, 32'h0000_00FF, 32'h0000_006B);
		m.start();
		send(8'h00, 1'b1);
		m.put_byte(iss_pkg::GC_RESET_CODE, ack);
		m.stop();
		rd_chk(iss_pkg::OFF_STAT, 32'h0000_0380, 32'h0000_0180);
		rd_chk(iss_pkg::OFF_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
		rd_chk(iss_pkg::OFF_ID0, 32'hFFFF_FFFF, 32'h0000_0000);
		rd_chk(iss_pkg::OFF_ALT, 32'hFFFF_FFFF, 32'h0000_0000);
		wr(iss_pkg::OFF_CTRL, 32'h0000_0020);
		rd_chk(iss_pkg::OFF_STAT, 32'h0000_0300, 32'h0000_0000);
		rd_chk(iss_pkg::OFF_STAT, 32'h0000_0080, 32'h0000_0000);
		rd_chk(iss_pkg::OFF_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
	endtask

	// ==========================================================
	// clock, reset and sequence
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	initial begin
		rst_n = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
		rready = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0000_0000; wstrb = 4'hF;
		repeat (8) @(posedge mclk);
		rst_n <= 1'b1;
		s_regs();
		s_write();
		s_overflow();
		s_read();
		s_nack();
		s_gc();
		summarize();
	end
endmodule
